// ### logic/csfr_cfg.svh
// Purpose: Constants for the CPU status and control word block.
// Assumes: Included by the design modules csfr_pscale and csfr_core.
// Notes: Bit positions follow the two status word layouts.
`ifndef CSFR_CFG_SVH
`define CSFR_CFG_SVH

// Status word zero fields.
`define CSFR_W0_PTR_HI 15
`define CSFR_W0_PTR_LO 13
`define CSFR_W0_OVF 12
`define CSFR_W0_SAT 11
`define CSFR_W0_RSV 10
`define CSFR_W0_MASK 9
`define CSFR_W0_PAGE_HI 8
`define CSFR_W0_PAGE_LO 0

// Status word one fields.
`define CSFR_W1_BAK_HI 15
`define CSFR_W1_BAK_LO 13
`define CSFR_W1_MAP 12
`define CSFR_W1_TEST 11
`define CSFR_W1_SXT 10
`define CSFR_W1_CARRY 9
`define CSFR_W1_UOUT 4
`define CSFR_W1_PM_HI 1
`define CSFR_W1_PM_LO 0
`define CSFR_W1_RSV_MASK 16'h01ec

// Reset values of the flag bits.
`define CSFR_RST_CARRY 1'b1
`define CSFR_RST_MAP 1'b0
`define CSFR_RST_MASK 1'b1
`define CSFR_RST_OVF 1'b0
`define CSFR_RST_SXT 1'b1
`define CSFR_RST_UOUT 1'b1
`define CSFR_RST_PM 2'h0
`define CSFR_RST_SAT 1'b0
`define CSFR_RST_TEST 1'b0
`define CSFR_RST_PTR 3'h0
`define CSFR_RST_PAGE 9'h000

`endif

// ### logic/csfr_pkg.sv
// Purpose: Types shared by the status word block.
// Assumes: Constants come from csfr_cfg.svh.
// Notes: None.
package csfr_pkg;

    // Flag selector used by the set and clear flag operations.
    typedef enum logic [2:0]
    {
        CSFR_FLG_CARRY = 3'h0,
        CSFR_FLG_MAP = 3'h1,
        CSFR_FLG_MASK = 3'h2,
        CSFR_FLG_SAT = 3'h3,
        CSFR_FLG_SXT = 3'h4,
        CSFR_FLG_UOUT = 3'h5
    } csfr_flag_t;

    // Explicit instruction requests from the decoder.
    typedef struct packed
    {
        logic set_flag_op;
        logic clear_flag_op;
        csfr_flag_t flag_sel;
        logic load_status_op;
        logic load_word_one;
        logic [15:0] load_data;
        logic load_pointer_op;
        logic modify_aux_op;
        logic indirect_ptr_ld;
        logic [2:0] ptr_value;
        logic load_page_op;
        logic [8:0] page_value;
        logic set_shift_op;
        logic [1:0] shift_value;
        logic cond_jump_op;
        logic cond_on_ovf;
    } csfr_cmd_t;

    // Implicit flag updates from the datapath.
    typedef struct packed
    {
        logic add_carry_upd;
        logic add_is_sub;
        logic add_shift16;
        logic add_carry;
        logic shift_carry_upd;
        logic shift_carry;
        logic alu_ovf;
        logic test_upd;
        logic test_value;
        logic irq_acknowledge;
        logic irq_trap;
    } csfr_dp_t;

    // Mode outputs steering the datapath.
    typedef struct packed
    {
        logic [2:0] aux_pointer;
        logic global_irq_mask;
        logic saturate_enable;
        logic sign_extend_enable;
        logic ram_to_program_map;
        logic [1:0] product_shift;
        logic test_flag;
        logic carry;
        logic sum_exceeded_latch;
    } csfr_mode_t;

endpackage

// ### logic/csfr_pscale.sv
// Purpose: Product path shifter between the product register and the ALU.
// Assumes: Product register contents arrive unchanged from the multiplier.
// Notes: Purely combinational, so the stored product is never altered.
`timescale 1ns/10ps
`include "csfr_cfg.svh"
module csfr_pscale
    import csfr_pkg::*;
#(
    parameter int W = 32
)
(
    input wire logic [1:0] product_shift,
    input wire logic [W-1:0] product_reg,
    output logic [W-1:0] shifted
);

    always_comb
    begin
        case (product_shift)
            2'h0: shifted = product_reg;
            2'h1: shifted = {product_reg[W-2:0], 1'b0};
            2'h2: shifted = {product_reg[W-5:0], 4'h0};
            2'h3: shifted = {{6{product_reg[W-1]}}, product_reg[W-1:6]};
            default: shifted = product_reg;
        endcase
    end

endmodule

// ### logic/csfr_core.sv
// Purpose: Two 16-bit CPU status and control words with their update logic.
// Assumes: One decoder request per cycle; datapath updates may coincide.
// Notes: Status store reads are combinational from the held flags.
//
// How it works
// - Any pointer load except status load copies the old pointer to backup.
// - Status load of word one writes backup and pointer with one value.
// - Pointer picks the indirect register; loaded by four instruction kinds.
// - Add sets carry on carry, subtract clears it on borrow, else opposite.
// - Shift-16 add may only set carry, subtract may only clear it.
// - Map bit zero puts dual-access RAM in data space, one in program.
// - Direct address is page pointer above seven instruction low bits.
// - Page pointer changes only by status load or load-page.
// - Mask one blocks maskable interrupts; reset and NMI never blocked.
// - Mask set by reset, acknowledge, trap; flag ops; status load ignores it.
// - Overflow latch sets on ALU overflow, cleared by reset, branch, load.
// - Saturate bit selects wrapping or clamping accumulator on overflow.
// - Saturate bit follows flag set, flag clear and status load.
// - Product shift field selects none, left one, left four, right six.
// - Shift only on transfer; field loaded by set-shift and load, reset clears.
// - Sign-extend bit enables extension unless the instruction forces it off.
// - Sign-extend bit follows flag ops, word-one load; reset sets it.
// - Test flag is offered as a branch, call and return condition.
// - Output flag drives the pin; flag ops set or clear; reset sets it.
// - Reserved bits read back as ones.
// - Status store reads both words; status load writes them.
`timescale 1ns/10ps
`include "csfr_cfg.svh"
module csfr_core
    import csfr_pkg::*;
#(
    parameter int PW = 32
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire csfr_cmd_t cmd,
    input wire csfr_dp_t dp,
    input wire logic [6:0] direct_offset,
    input wire logic force_no_extend,
    input wire logic irq_maskable_req,
    input wire logic [PW-1:0] product_reg,
    output logic [15:0] direct_addr,
    output logic irq_accept,
    output logic extend_active,
    output logic [PW-1:0] product_scaled,
    output logic [15:0] status_word_zero,
    output logic [15:0] status_word_one,
    output csfr_mode_t mode,
    output logic user_output_pin
);

    // ****************************************
    // Held state
    // ****************************************
    logic [2:0] aux_pointer_r;
    logic [2:0] aux_pointer_backup_r;
    logic [8:0] page_pointer_r;
    logic carry_r;
    logic ram_to_program_map_r;
    logic global_irq_mask_r;
    logic sum_exceeded_latch_r;
    logic saturate_enable_r;
    logic sign_extend_enable_r;
    logic test_flag_r;
    logic user_output_flag_r;
    logic [1:0] product_shift_r;

    logic ld0;
    logic ld1;
    logic set_hit;
    logic clr_hit;
    logic ptr_ld;

    assign ld0 = cmd.load_status_op && !cmd.load_word_one;
    assign ld1 = cmd.load_status_op && cmd.load_word_one;
    assign set_hit = cmd.set_flag_op;
    assign clr_hit = cmd.clear_flag_op;
    assign ptr_ld = cmd.load_pointer_op || cmd.modify_aux_op || cmd.indirect_ptr_ld;

    // ****************************************
    // Pointer and backup
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aux_pointer_r <= `CSFR_RST_PTR;
            aux_pointer_backup_r <= `CSFR_RST_PTR;
        end
        else if (ld1)
        begin
            // Backup and pointer take the same loaded value.
            aux_pointer_backup_r <= cmd.load_data[`CSFR_W1_BAK_HI:`CSFR_W1_BAK_LO];
            aux_pointer_r <= cmd.load_data[`CSFR_W1_BAK_HI:`CSFR_W1_BAK_LO];
        end
        else if (ld0)
        begin
            aux_pointer_r <= cmd.load_data[`CSFR_W0_PTR_HI:`CSFR_W0_PTR_LO];
        end
        else if (ptr_ld)
        begin
            aux_pointer_backup_r <= aux_pointer_r;
            aux_pointer_r <= cmd.ptr_value;
        end
    end

    // ****************************************
    // Page pointer
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            page_pointer_r <= `CSFR_RST_PAGE;
        end
        else if (ld0)
        begin
            page_pointer_r <= cmd.load_data[`CSFR_W0_PAGE_HI:`CSFR_W0_PAGE_LO];
        end
        else if (cmd.load_page_op)
        begin
            page_pointer_r <= cmd.page_value;
        end
    end

    assign direct_addr = {page_pointer_r, direct_offset};

    // ****************************************
    // Carry
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            carry_r <= `CSFR_RST_CARRY;
        end
        else if (ld1)
        begin
            carry_r <= cmd.load_data[`CSFR_W1_CARRY];
        end
        else if ((set_hit || clr_hit) && cmd.flag_sel == CSFR_FLG_CARRY)
        begin
            carry_r <= set_hit;
        end
        else if (dp.add_carry_upd && dp.add_shift16)
        begin
            // The ALU reports carry out for adds and not-borrow for subtracts.
            if (!dp.add_is_sub && dp.add_carry)
            begin
                carry_r <= 1'b1;
            end
            else if (dp.add_is_sub && !dp.add_carry)
            begin
                carry_r <= 1'b0;
            end
        end
        else if (dp.add_carry_upd)
        begin
            carry_r <= dp.add_carry;
        end
        else if (dp.shift_carry_upd)
        begin
            carry_r <= dp.shift_carry;
        end
    end

    // ****************************************
    // Mode bits set by flag operations, status loads and set-shift
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ram_to_program_map_r <= `CSFR_RST_MAP;
            sign_extend_enable_r <= `CSFR_RST_SXT;
            user_output_flag_r <= `CSFR_RST_UOUT;
            saturate_enable_r <= `CSFR_RST_SAT;
            product_shift_r <= `CSFR_RST_PM;
        end
        else
        begin
            if (ld1)
            begin
                ram_to_program_map_r <= cmd.load_data[`CSFR_W1_MAP];
                sign_extend_enable_r <= cmd.load_data[`CSFR_W1_SXT];
                product_shift_r <= cmd.load_data[`CSFR_W1_PM_HI:`CSFR_W1_PM_LO];
            end
            else if (cmd.set_shift_op)
            begin
                product_shift_r <= cmd.shift_value;
            end
            if (ld0)
            begin
                saturate_enable_r <= cmd.load_data[`CSFR_W0_SAT];
            end
            if (set_hit || clr_hit)
            begin
                case (cmd.flag_sel)
                    CSFR_FLG_MAP: ram_to_program_map_r <= set_hit;
                    CSFR_FLG_SXT: sign_extend_enable_r <= set_hit;
                    CSFR_FLG_SAT: saturate_enable_r <= set_hit;
                    CSFR_FLG_UOUT: user_output_flag_r <= set_hit;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Interrupt mask
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            global_irq_mask_r <= `CSFR_RST_MASK;
        end
        else if ((set_hit || clr_hit) && cmd.flag_sel == CSFR_FLG_MASK)
        begin
            global_irq_mask_r <= set_hit;
        end
        else if (dp.irq_acknowledge || dp.irq_trap)
        begin
            global_irq_mask_r <= 1'b1;
        end
    end

    // Reset and non-maskable interrupts do not pass through here at all.
    assign irq_accept = irq_maskable_req && !global_irq_mask_r;

    // ****************************************
    // Overflow latch and test flag
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sum_exceeded_latch_r <= `CSFR_RST_OVF;
        end
        else if (ld0)
        begin
            sum_exceeded_latch_r <= cmd.load_data[`CSFR_W0_OVF];
        end
        else if (dp.alu_ovf)
        begin
            // A new overflow outranks the branch clear so no event is lost.
            sum_exceeded_latch_r <= 1'b1;
        end
        else if (cmd.cond_jump_op && cmd.cond_on_ovf)
        begin
            sum_exceeded_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            test_flag_r <= `CSFR_RST_TEST;
        end
        else if (ld1)
        begin
            test_flag_r <= cmd.load_data[`CSFR_W1_TEST];
        end
        else if (dp.test_upd)
        begin
            test_flag_r <= dp.test_value;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign extend_active = sign_extend_enable_r && !force_no_extend;
    assign user_output_pin = user_output_flag_r;

    csfr_pscale #(
        .W(PW)
    ) u_pscale (
        .product_shift(product_shift_r),
        .product_reg(product_reg),
        .shifted(product_scaled)
    );

    always_comb
    begin
        status_word_zero = {aux_pointer_r, sum_exceeded_latch_r, saturate_enable_r, 1'b1,
                            global_irq_mask_r, page_pointer_r};
        status_word_one = `CSFR_W1_RSV_MASK;
        status_word_one[`CSFR_W1_BAK_HI:`CSFR_W1_BAK_LO] = aux_pointer_backup_r;
        status_word_one[`CSFR_W1_MAP] = ram_to_program_map_r;
        status_word_one[`CSFR_W1_TEST] = test_flag_r;
        status_word_one[`CSFR_W1_SXT] = sign_extend_enable_r;
        status_word_one[`CSFR_W1_CARRY] = carry_r;
        status_word_one[`CSFR_W1_UOUT] = user_output_flag_r;
        status_word_one[`CSFR_W1_PM_HI:`CSFR_W1_PM_LO] = product_shift_r;
        status_word_one[`CSFR_W1_PM_HI + 1] = 1'b1;
    end

    always_comb
    begin
        mode.aux_pointer = aux_pointer_r;
        mode.global_irq_mask = global_irq_mask_r;
        mode.saturate_enable = saturate_enable_r;
        mode.sign_extend_enable = sign_extend_enable_r;
        mode.ram_to_program_map = ram_to_program_map_r;
        mode.product_shift = product_shift_r;
        mode.test_flag = test_flag_r;
        mode.carry = carry_r;
        mode.sum_exceeded_latch = sum_exceeded_latch_r;
    end

endmodule

// ### test/csfr_core_checker.sv
// Purpose: Port-level checks on the status word block.
// Assumes: Sees only the top ports; one clock domain.
// Notes: Bound to every csfr_core instance.
`timescale 1ns/10ps
module csfr_core_checker
    import csfr_pkg::*;
#(
    parameter int PW = 32
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire csfr_cmd_t cmd,
    input wire csfr_dp_t dp,
    input wire logic [6:0] direct_offset,
    input wire logic force_no_extend,
    input wire logic irq_maskable_req,
    input wire logic [PW-1:0] product_reg,
    input wire logic [15:0] direct_addr,
    input wire logic irq_accept,
    input wire logic extend_active,
    input wire logic [PW-1:0] product_scaled,
    input wire logic [15:0] status_word_zero,
    input wire logic [15:0] status_word_one,
    input wire csfr_mode_t mode,
    input wire logic user_output_pin
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_RSV_ONES: assert property (status_word_zero[10] && ((status_word_one & 16'h01ec) == 16'h01ec))
        else $error("reserved bits not one");
    AST_DIRECT: assert property (direct_addr == {status_word_zero[8:0], direct_offset})
        else $error("direct address wrong");
    AST_IRQ: assert property (irq_accept == (irq_maskable_req && !status_word_zero[9]))
        else $error("irq accept wrong");
    AST_EXT: assert property (extend_active == (status_word_one[10] && !force_no_extend))
        else $error("extend wrong");
    AST_PIN: assert property (user_output_pin == status_word_one[4])
        else $error("pin differs from flag");
    AST_BACKUP: assert property ((cmd.load_pointer_op || cmd.modify_aux_op || cmd.indirect_ptr_ld)
        && !cmd.load_status_op |=> status_word_one[15:13] == $past(status_word_zero[15:13])
        && status_word_zero[15:13] == $past(cmd.ptr_value)) else $error("pointer backup wrong");
    AST_PAGE: assert property (!cmd.load_status_op && !cmd.load_page_op |=> $stable(status_word_zero[8:0]))
        else $error("page changed");
    AST_MASK_ACK: assert property ((dp.irq_acknowledge || dp.irq_trap) && !cmd.clear_flag_op
        |=> status_word_zero[9]) else $error("mask not set");
    AST_MASK_LOAD: assert property (cmd.load_status_op && !cmd.set_flag_op && !cmd.clear_flag_op
        && !dp.irq_acknowledge && !dp.irq_trap
        |=> status_word_zero[9] == $past(status_word_zero[9])) else $error("load moved mask");
    AST_MODE_COPY: assert property (mode.aux_pointer == status_word_zero[15:13]
        && mode.global_irq_mask == status_word_zero[9] && mode.saturate_enable == status_word_zero[11]
        && mode.sum_exceeded_latch == status_word_zero[12] && mode.sign_extend_enable == status_word_one[10]
        && mode.ram_to_program_map == status_word_one[12] && mode.product_shift == status_word_one[1:0]
        && mode.test_flag == status_word_one[11] && mode.carry == status_word_one[9])
        else $error("mode copy differs from status words");
    AST_OVF_SET: assert property (dp.alu_ovf && !cmd.load_status_op |=> status_word_zero[12])
        else $error("overflow not latched");
    AST_OVF_HOLD: assert property (status_word_zero[12] && !cmd.load_status_op && !cmd.cond_jump_op
        |=> status_word_zero[12]) else $error("overflow dropped");

    cover property (cmd.load_status_op && cmd.load_word_one);
    cover property (dp.alu_ovf && cmd.cond_jump_op);
    cover property (irq_accept);
endmodule
bind csfr_core csfr_core_checker #(.PW(PW)) csfr_core_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd(cmd), .dp(dp), .direct_offset(direct_offset), .force_no_extend(force_no_extend),
    .irq_maskable_req(irq_maskable_req), .product_reg(product_reg), .direct_addr(direct_addr),
    .irq_accept(irq_accept), .extend_active(extend_active), .product_scaled(product_scaled),
    .status_word_zero(status_word_zero), .status_word_one(status_word_one), .mode(mode),
    .user_output_pin(user_output_pin));

// ### test/csfr_dec_model.sv
// Purpose: Decoder and datapath stand-in driving requests.
// Assumes: One request per call, idle cycle after it.
// Notes: Requests last exactly one cycle, as the real decoder does.
`timescale 1ns/10ps
module csfr_dec_model
    import csfr_pkg::*;
(
    input wire logic clk_sys,
    output csfr_cmd_t cmd,
    output csfr_dp_t dp
);
    initial
    begin
        cmd = '0;
        dp = '0;
    end

    // Driving just after the edge keeps the sample race-free.
    task automatic issue(input csfr_cmd_t c, input csfr_dp_t d);
        @(posedge clk_sys);
        #1;
        cmd = c;
        dp = d;
        @(posedge clk_sys);
        #1;
        cmd = '0;
        dp = '0;
    endtask
endmodule

// ### test/cpu_status_flag_registers_tb.sv
// Purpose: Self-checking bench for the status word block.
// Assumes: Decoder model issues one request per call.
// Notes: Seeded random data mixed with fixed corner cases.
`timescale 1ns/10ps
module cpu_status_flag_registers_tb;
    import csfr_pkg::*;
    logic clk_sys;
    logic rst_n;
    csfr_cmd_t cmd;
    csfr_cmd_t c;
    csfr_dp_t dp;
    csfr_dp_t d;
    logic [6:0] direct_offset;
    logic force_no_extend;
    logic irq_maskable_req;
    logic [31:0] product_reg;
    logic [15:0] direct_addr;
    logic irq_accept;
    logic extend_active;
    logic [31:0] product_scaled;
    logic [15:0] status_word_zero;
    logic [15:0] status_word_one;
    csfr_mode_t mode;
    logic user_output_pin;
    int errors = 0;
    int n_compared = 0;
    int i;
    int pos[6] = '{25, 28, 9, 11, 26, 20};
    logic [31:0] r;
    logic [15:0] w;
    logic o;

    csfr_core csfr_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .dp(dp),
        .direct_offset(direct_offset), .force_no_extend(force_no_extend),
        .irq_maskable_req(irq_maskable_req), .product_reg(product_reg), .direct_addr(direct_addr),
        .irq_accept(irq_accept), .extend_active(extend_active), .product_scaled(product_scaled),
        .status_word_zero(status_word_zero), .status_word_one(status_word_one), .mode(mode),
        .user_output_pin(user_output_pin));
    csfr_dec_model csfr_dec_model_i (.clk_sys(clk_sys), .cmd(cmd), .dp(dp));

    always #4 clk_sys = ~clk_sys;

    // ****************************************
    // Helpers
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task go();
        csfr_dec_model_i.issue(c, d);
        c = '0;
        d = '0;
    endtask

    function automatic logic [31:0] ps(input logic [1:0] m, input logic [31:0] p);
        case (m)
            2'h1: ps = p << 1;
            2'h2: ps = p << 4;
            2'h3: ps = $signed(p) >>> 6;
            default: ps = p;
        endcase
    endfunction

    // A shift-16 add or subtract can only move carry one way.
    function automatic logic cy(input logic sub, input logic s16, input logic ac, input logic old);
        if (!s16)
            cy = ac;
        else if (sub)
            cy = old & ac;
        else
            cy = old | ac;
    endfunction

    task close_out();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        close_out();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        direct_offset = '0;
        force_no_extend = 1'b0;
        irq_maskable_req = 1'b0;
        product_reg = '0;
        c = '0;
        d = '0;
        void'($urandom(32'he0c2));
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        chk("w0", 32'h0600, status_word_zero);
        chk("w1", 32'h07fc, status_word_one);
        for (i = 0; i < 9; i++)
        begin
            w = status_word_zero;
            r = $urandom;
            c.ptr_value = r[2:0];
            c.load_pointer_op = (i % 3 == 0);
            c.modify_aux_op = (i % 3 == 1);
            c.indirect_ptr_ld = (i % 3 == 2);
            go();
            chk("ptr", r[2:0], status_word_zero[15:13]);
            chk("bak", w[15:13], status_word_one[15:13]);
        end
        // A datapath carry in the same cycle must lose to a word-one load.
        for (i = 0; i < 6; i++)
        begin
            r = $urandom;
            w = i[0] ? status_word_one : status_word_zero;
            c.load_status_op = 1'b1;
            c.load_word_one = i[0];
            c.load_data = r[15:0];
            d.shift_carry_upd = 1'b1;
            d.shift_carry = ~r[9];
            go();
            if (i[0])
                chk("w1l", (r[15:0] & 16'hffef) | 16'h01ec | (w & 16'h0010), status_word_one);
            else
                chk("w0l", (r[15:0] & 16'hf9ff) | 16'h0400 | (w & 16'h0200), status_word_zero);
            if (i[0])
                chk("ptrl", r[15:13], status_word_zero[15:13]);
        end
        for (i = 0; i < 12; i++)
        begin
            c.set_flag_op = ~i[0];
            c.clear_flag_op = i[0];
            c.flag_sel = csfr_flag_t'(i[3:1]);
            go();
            r = {status_word_one, status_word_zero};
            chk("flag", !i[0], r[pos[i[3:1]]]);
        end
        chk("pin", 0, user_output_pin);
        chk("map", 0, mode.ram_to_program_map);
        irq_maskable_req = 1'b1;
        #1 chk("acc", 1, irq_accept);
        d.irq_acknowledge = 1'b1;
        go();
        chk("acc", 0, irq_accept);
        c.clear_flag_op = 1'b1;
        c.flag_sel = CSFR_FLG_MASK;
        go();
        d.irq_trap = 1'b1;
        go();
        chk("msk", 1, status_word_zero[9]);
        for (i = 0; i < 4; i++)
        begin
            c.set_flag_op = i[1];
            c.flag_sel = CSFR_FLG_SXT;
            force_no_extend = i[0];
            go();
            chk("ext", i[1] & ~i[0], extend_active);
        end
        for (i = 0; i < 16; i++)
        begin
            r = $urandom;
            o = status_word_one[9];
            d.add_carry_upd = ~r[3];
            d.add_is_sub = r[0];
            d.add_shift16 = r[1];
            d.add_carry = r[2];
            d.shift_carry_upd = r[3];
            d.shift_carry = r[2];
            go();
            chk("cy", r[3] ? r[2] : cy(r[0], r[1], r[2], o), status_word_one[9]);
        end
        for (i = 0; i < 4; i++)
        begin
            d.alu_ovf = (i < 3);
            c.cond_jump_op = i[1];
            c.cond_on_ovf = i[1];
            go();
            chk("ovf", i < 3, status_word_zero[12]);
        end
        for (i = 0; i < 2; i++)
        begin
            d.test_upd = 1'b1;
            d.test_value = ~i[0];
            go();
            chk("tc", !i[0], mode.test_flag);
            chk("tcw", !i[0], status_word_one[11]);
        end
        for (i = 0; i < 4; i++)
        begin
            r = $urandom;
            c.load_page_op = 1'b1;
            c.page_value = r[8:0];
            c.set_shift_op = 1'b1;
            c.shift_value = i[1:0];
            direct_offset = r[15:9];
            product_reg = r;
            go();
            chk("da", {r[8:0], r[15:9]}, direct_addr);
            chk("ps", ps(i[1:0], r), product_scaled);
            chk("pm", i[1:0], status_word_one[1:0]);
        end
        close_out();
    end
endmodule
